// File: shared/smt_pkg.sv
// Package holding the register map, field positions and enums of the timer.
`default_nettype none
package smt_pkg;
  // Byte addresses of the register file.
  localparam logic [11:0] COUNT_ADDR   = 12'h48c;
  localparam logic [11:0] CPER_ADDR    = 12'h48f;
  localparam logic [11:0] CWID_ADDR    = 12'h492;
  localparam logic [11:0] PLIM_ADDR    = 12'h495;
  localparam logic [11:0] CTRL0_ADDR   = 12'h498;
  localparam logic [11:0] CTRL1_ADDR   = 12'h499;
  localparam logic [11:0] STATE_ADDR   = 12'h49a;
  localparam logic [11:0] CLKSEL_ADDR  = 12'h49b;
  localparam logic [11:0] SIGSEL_ADDR  = 12'h49c;
  localparam logic [11:0] WINSEL_ADDR  = 12'h49d;
  localparam logic [11:0] IRQFLAG_ADDR = 12'h49e;
  localparam logic [11:0] IRQEN_ADDR   = 12'h49f;
  // Field positions.
  localparam int CTRL0_EN_BIT     = 7;
  localparam int CTRL0_HALT_BIT   = 5;
  localparam int CTRL1_GO_BIT     = 7;
  localparam int CTRL1_REPEAT_BIT = 6;
  localparam int STATE_PERLATCH   = 7;
  localparam int STATE_WIDLATCH   = 6;
  localparam int STATE_RUN_BIT    = 2;
  localparam int STATE_WIN_BIT    = 1;
  localparam int STATE_SIG_BIT    = 0;
  localparam int FLAG_WIDTH_BIT   = 0;
  localparam int FLAG_PERIOD_BIT  = 1;
  localparam int FLAG_MATCH_BIT   = 2;
  // Field masks and reset values.
  localparam logic [7:0] CTRL1_MODE_MASK = 8'h0f;
  localparam logic [7:0] CLKSEL_MASK     = 8'h07;
  localparam logic [7:0] SRCSEL_MASK     = 8'h1f;
  localparam logic [7:0] REG8_RESET      = 8'h00;
  localparam logic [2:0] FLAG_MASK       = 3'h7;
  localparam logic [23:0] COUNT_RESET    = 24'h000000;
  localparam logic [23:0] PLIM_RESET     = 24'hffffff;
  localparam logic [23:0] COUNT_ONE      = 24'h000001;
  // Clock sources that die in sleep.
  localparam logic [2:0] CSEL_SYSOSC     = 3'h0;
  localparam logic [2:0] CSEL_SYSOSC_DIV = 3'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HELD} run_t;
endpackage
`default_nettype wire

// File: logic/signal_measure_timer_regs.sv
// Register file, counter and event logic of the signal measurement timer.
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
// Operation
// R1 - Width capture flag rises whenever captured width register is loaded.
// R2 - Period capture flag rises whenever captured period register is loaded.
// R3 - Period match flag rises when counter equals period limit.
// R4 - Each event gated to interrupt by its own enable bit.
// R5 - Counting and capture continue in low-power states while sources run.
// R6 - System oscillator clock sources stop the counter during sleep.
// R7 - Counter is 24-bit read/write, cleared at reset.
// R8 - Counter reachable as low, middle and upper byte registers.
// R9 - Captured period is read-only and holds counter at period capture.
// R10 - Captured period unknown at power-up, kept through other resets.
// R11 - Captured period readable as three byte registers.
// R12 - Halt bit holds counter at limit; else it returns to zero.
// R13 - Single acquisition stops counter and clears run request.
// R14 - Soft latch bits copy counter into width or period capture.
// R15 - Basic timer match resets the counter and raises match event.
// R16 - Flags sticky until software clears; irq is OR of enabled flags.
module signal_measure_timer_regs
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [7:0]  rdata_o,
  // Timing sources from outside the clock domain
  input  wire logic        count_tick_i,
  input  wire logic        signal_i,
  input  wire logic        window_i,
  input  wire logic        sleep_i,
  // Capture strobes from the mode sequencer, same clock
  input  wire logic        width_capture_i,
  input  wire logic        period_capture_i,
  // Interrupt and activity
  output var  logic        irq_o,
  output var  logic        running_o
);
  import smt_pkg::*;

  logic [23:0] count_value;
  logic [23:0] captured_period;
  logic [23:0] captured_width;
  logic [23:0] period_limit;
  logic [7:0]  control_primary;
  logic [7:0]  control_run_mode;
  logic [7:0]  clock_source_select;
  logic [7:0]  signal_source_select;
  logic [7:0]  window_source_select;
  logic [2:0]  irq_flags;
  logic [2:0]  peripheral_irq_enable_reg;
  logic        width_soft_latch;
  logic        period_soft_latch;
  logic        run_held;
  run_t        run_state;

  // Three sync flops and a filter flop per outside input; a change counts once stages 2 and 3 agree.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] filt;
  wire  [3:0] raw_in = {sleep_i, window_i, signal_i, count_tick_i};

  // Every stage resets to the idle low level, so no false edge follows.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          filt[g]  <= 1'b0;
        end
        else
        begin
          sync1[g] <= raw_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g])
            filt[g] <= sync3[g];
        end
      end
    end
  endgenerate

  wire tick_sync   = filt[0];
  wire signal_sync = filt[1];
  wire window_sync = filt[2];
  wire sleep_sync  = filt[3];

  // The external tick counts on its rising edge only.
  logic tick_prev;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tick_prev <= 1'b0;
    else
      tick_prev <= tick_sync;
  end

  // Register decode. The captured registers have no write decode, so writes
  // to them are dropped.
  wire wr_cnt_l   = wr_i && addr_i == COUNT_ADDR;
  wire wr_cnt_m   = wr_i && addr_i == COUNT_ADDR + 12'h001;
  wire wr_cnt_u   = wr_i && addr_i == COUNT_ADDR + 12'h002;
  wire wr_count   = wr_cnt_l | wr_cnt_m | wr_cnt_u;
  wire wr_plim    = wr_i && addr_i >= PLIM_ADDR
                    && addr_i <= PLIM_ADDR + 12'h002;
  wire [1:0] plim_lane = 2'(addr_i - PLIM_ADDR);
  wire wr_ctrl0   = wr_i && addr_i == CTRL0_ADDR;
  wire wr_ctrl1   = wr_i && addr_i == CTRL1_ADDR;
  wire wr_state   = wr_i && addr_i == STATE_ADDR;
  wire wr_clksel  = wr_i && addr_i == CLKSEL_ADDR;
  wire wr_sigsel  = wr_i && addr_i == SIGSEL_ADDR;
  wire wr_winsel  = wr_i && addr_i == WINSEL_ADDR;
  wire wr_flags   = wr_i && addr_i == IRQFLAG_ADDR;
  wire wr_irqen   = wr_i && addr_i == IRQEN_ADDR;

  wire enabled    = control_primary[CTRL0_EN_BIT];
  wire go         = control_run_mode[CTRL1_GO_BIT];
  wire repeat_on  = control_run_mode[CTRL1_REPEAT_BIT];
  wire halt_at_period = control_primary[CTRL0_HALT_BIT];
  wire [2:0] csel = clock_source_select[2:0];

  // System oscillator based clocks stop in sleep; other sources keep going.
  wire sysclk_src = csel == CSEL_SYSOSC || csel == CSEL_SYSOSC_DIV; // R6
  wire clock_alive = !(sysclk_src && sleep_sync); // R5 R6
  wire tick = sysclk_src ? 1'b1 : (tick_sync && !tick_prev);
  wire advance = enabled && go && !run_held && clock_alive && tick; // R5

  wire at_limit = count_value == period_limit;
  wire match_ev = advance && at_limit; // R3
  wire width_ld  = enabled && (width_capture_i || width_soft_latch); // R14
  wire period_ld = enabled && (period_capture_i || period_soft_latch); // R14
  wire acq_done  = width_ld || period_ld;
  wire stop_single = !repeat_on && acq_done; // R13

  // Run state transitions.
  wire run_start = enabled && go;
  wire run_stop  = !enabled || !go;
  wire run_hold  = match_ev && halt_at_period;

  // Counter. Bytes land one write at a time, so software should stop the
  // count before rewriting it, or a carry may slip between the bytes.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count_value <= COUNT_RESET; // R7
    else if (wr_cnt_l)
      count_value[7:0] <= wdata_i; // R8
    else if (wr_cnt_m)
      count_value[15:8] <= wdata_i; // R8
    else if (wr_cnt_u)
      count_value[23:16] <= wdata_i; // R8
    else if (match_ev && !halt_at_period)
      count_value <= COUNT_RESET; // R12 R15
    else if (advance && !at_limit)
      count_value <= count_value + COUNT_ONE;
  end

  // The hold at the limit lasts until software rewrites the count or clears the run request.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      run_held <= 1'b0;
    else if (wr_count || !go)
      run_held <= 1'b0;
    else if (run_hold)
      run_held <= 1'b1; // R12
  end

  // Captures keep no reset so that only power-up leaves them unknown.
  always_ff @(posedge clk_i)
  begin
    if (period_ld)
      captured_period <= count_value; // R9 R10
    if (width_ld)
      captured_width <= count_value;
  end

  // Control and selector registers.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      period_limit         <= PLIM_RESET;
      control_primary      <= REG8_RESET;
      control_run_mode     <= REG8_RESET;
      clock_source_select  <= REG8_RESET;
      signal_source_select <= REG8_RESET;
      window_source_select <= REG8_RESET;
      peripheral_irq_enable_reg <= 3'h0;
      width_soft_latch     <= 1'b0;
      period_soft_latch    <= 1'b0;
    end
    else
    begin
      if (wr_plim)
        period_limit[8*plim_lane +: 8] <= wdata_i;
      if (wr_ctrl0)
        control_primary <= wdata_i;
      if (wr_ctrl1)
        control_run_mode <= wdata_i;
      else if (stop_single)
        control_run_mode[CTRL1_GO_BIT] <= 1'b0; // R13
      // Selector writes keep only the bits that the fields use.
      if (wr_clksel)
        clock_source_select <= wdata_i & CLKSEL_MASK;
      if (wr_sigsel)
        signal_source_select <= wdata_i & SRCSEL_MASK;
      if (wr_winsel)
        window_source_select <= wdata_i & SRCSEL_MASK;
      if (wr_irqen)
        peripheral_irq_enable_reg <= wdata_i[2:0] & FLAG_MASK;
      // Latch bits self-clear once the copy is made.
      width_soft_latch  <= wr_state && wdata_i[STATE_WIDLATCH]; // R14
      period_soft_latch <= wr_state && wdata_i[STATE_PERLATCH]; // R14
    end
  end

  // Sticky event flags: a new event wins over a write-one clear.
  wire [2:0] flag_set;
  assign flag_set[FLAG_WIDTH_BIT]  = width_ld; // R1
  assign flag_set[FLAG_PERIOD_BIT] = period_ld; // R2
  assign flag_set[FLAG_MATCH_BIT]  = match_ev; // R3
  wire [2:0] flag_clr = wr_flags ? wdata_i[2:0] : 3'h0;
  wire [2:0] next_flags = (irq_flags & ~flag_clr) | flag_set; // R16

  // Enables written in this cycle already count for the level output.
  wire [2:0] next_irq_en = wr_irqen ? (wdata_i[2:0] & FLAG_MASK)
                                    : peripheral_irq_enable_reg;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_flags <= 3'h0;
    else
      irq_flags <= next_flags;
  end

  // The level output follows the flags and enables of the coming cycle.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(next_flags & next_irq_en); // R4 R16
  end

  // Run state for the status register; running_o follows advance.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      run_state <= ST_IDLE;
    else
    begin
      unique case (run_state)
        ST_IDLE:
        begin
          if (run_start)
            run_state <= ST_RUN;
        end
        ST_RUN:
        begin
          if (run_stop)
            run_state <= ST_IDLE;
          else if (run_hold)
            run_state <= ST_HELD;
        end
        ST_HELD:
        begin
          if (run_stop || wr_count)
            run_state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      running_o <= 1'b0;
    else
      running_o <= advance;
  end

  // Read mux; unmapped addresses read zero.
  // The latch strobes are write-only and read back as zero.
  logic [7:0] status_byte;
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[STATE_RUN_BIT] = run_state == ST_RUN;
    status_byte[STATE_WIN_BIT] = window_sync;
    status_byte[STATE_SIG_BIT] = signal_sync;
  end

  logic [7:0] next_rdata;
  always_comb
  begin
    unique case (addr_i)
      COUNT_ADDR:          next_rdata = count_value[7:0]; // R8
      COUNT_ADDR + 12'h001: next_rdata = count_value[15:8];
      COUNT_ADDR + 12'h002: next_rdata = count_value[23:16];
      CPER_ADDR:           next_rdata = captured_period[7:0]; // R11
      CPER_ADDR + 12'h001: next_rdata = captured_period[15:8];
      CPER_ADDR + 12'h002: next_rdata = captured_period[23:16];
      CWID_ADDR:           next_rdata = captured_width[7:0];
      CWID_ADDR + 12'h001: next_rdata = captured_width[15:8];
      CWID_ADDR + 12'h002: next_rdata = captured_width[23:16];
      PLIM_ADDR:           next_rdata = period_limit[7:0];
      PLIM_ADDR + 12'h001: next_rdata = period_limit[15:8];
      PLIM_ADDR + 12'h002: next_rdata = period_limit[23:16];
      CTRL0_ADDR:          next_rdata = control_primary;
      CTRL1_ADDR:          next_rdata = control_run_mode;
      STATE_ADDR:          next_rdata = status_byte;
      CLKSEL_ADDR:         next_rdata = clock_source_select;
      SIGSEL_ADDR:         next_rdata = signal_source_select;
      WINSEL_ADDR:         next_rdata = window_source_select;
      IRQFLAG_ADDR:        next_rdata = {5'h00, irq_flags};
      IRQEN_ADDR:          next_rdata = {5'h00, peripheral_irq_enable_reg};
      default:             next_rdata = 8'h00;
    endcase
  end

  // Read data fall back to zero outside their slot, so that several blocks
  // may share one OR-ed read bus.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end
endmodule
`default_nettype wire

// File: test/signal_measure_timer_regs_properties.sv
// Port-level assertions for the signal measurement timer registers.
`default_nettype none
module signal_measure_timer_regs_properties
  import smt_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // Timing sources and capture strobes
  input wire logic        count_tick_i,
  input wire logic        signal_i,
  input wire logic        window_i,
  input wire logic        sleep_i,
  input wire logic        width_capture_i,
  input wire logic        period_capture_i,
  // Interrupt and activity
  input wire logic        irq_o,
  input wire logic        running_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // A match shows only through running_o, so it counts as a flag cause.
  wire logic cause = width_capture_i | period_capture_i | wr_i | running_o;
  wire logic stop1 = wr_i && addr_i == CTRL1_ADDR && !wdata_i[CTRL1_GO_BIT];
  wire logic stop0 = wr_i && addr_i == CTRL0_ADDR && !wdata_i[CTRL0_EN_BIT];
  wire logic mask0 = wr_i && addr_i == IRQEN_ADDR && wdata_i == 8'h00;

  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside its slot");
  chk_unmapped_read: assert property
    (rd_i && addr_i == 12'h48b |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
  chk_quiet_reset: assert property
    ($rose(rstn_i) |-> !irq_o && !running_o)
    else $error("outputs active right after reset");
  chk_irq_sticky: assert property (irq_o && !wr_i |=> irq_o)
    else $error("interrupt dropped without a write");
  chk_irq_cause: assert property
    ($rose(irq_o) |-> $past(cause) || $past(cause, 2) || running_o)
    else $error("interrupt rose without an event");
  chk_irq_mask: assert property (mask0 |-> ##[1:2] !irq_o)
    else $error("interrupt stays up with all enables off");
  chk_go_stop: assert property (stop1 |-> ##3 !running_o)
    else $error("counter advances after run request cleared");
  chk_en_stop: assert property (stop0 |-> ##3 !running_o)
    else $error("counter advances while disabled");

  cov_irq_rise: cover property ($rose(irq_o));
  cov_running: cover property (running_o ##1 running_o);
  cov_irq_clear: cover property (irq_o ##1 !irq_o);
endmodule
bind signal_measure_timer_regs signal_measure_timer_regs_properties i_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_tick_i(count_tick_i),
  .signal_i(signal_i), .window_i(window_i), .sleep_i(sleep_i),
  .width_capture_i(width_capture_i), .period_capture_i(period_capture_i),
  .irq_o(irq_o), .running_o(running_o));
`default_nettype wire

// File: test/signal_measure_timer_regs_tb.sv
// Self-checking bench for the signal measurement timer register block.
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); \
  end end
module signal_measure_timer_regs_tb import smt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0]  wdata_i = 8'h00, rdata_o;
  logic        count_tick_i = 1'b0, signal_i = 1'b0, window_i = 1'b0;
  logic        sleep_i = 1'b0, width_capture_i = 1'b0, period_capture_i = 1'b0;
  logic        irq_o, running_o;
  int          n_mismatch = 0, total_checks = 0, cycles = 0;
  int          seed = 32'h2fc9ff55;

  signal_measure_timer_regs i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_tick_i(count_tick_i),
    .signal_i(signal_i), .window_i(window_i), .sleep_i(sleep_i),
    .width_capture_i(width_capture_i), .period_capture_i(period_capture_i),
    .irq_o(irq_o), .running_o(running_o));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // Noise on the status inputs proves they never disturb the counter.
  always @(posedge clk_i)
  begin
    signal_i <= 1'($random(seed));
    window_i <= 1'($random(seed));
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  function automatic logic [7:0] flag_of(input int b);
    return 8'h01 << b;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  task automatic wr24(input logic [11:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) wr(a + 12'(i), v[8*i +: 8]);
  endtask

  task automatic rd24(input logic [11:0] a, output logic [23:0] v);
    logic [7:0] b;
    for (int i = 0; i < 3; i++)
    begin
      rd(a + 12'(i), b);
      v[8*i +: 8] = b;
    end
  endtask

  task automatic cap(input bit per);
    @(posedge clk_i);
    period_capture_i <= per;
    width_capture_i  <= !per;
    @(posedge clk_i);
    period_capture_i <= 1'b0;
    width_capture_i  <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    logic [23:0] v, r;
    logic [7:0]  b;
    logic        saw;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd24(COUNT_ADDR, r);
    `CHK(r, COUNT_RESET)
    rd(12'h48b, b);
    `CHK(b, 8'h00)
    repeat (4)
    begin
      v = 24'($random(seed));
      wr24(COUNT_ADDR, v);
      rd24(COUNT_ADDR, r);
      `CHK(r, v)
    end
    wr(CTRL0_ADDR, 8'h80);
    cap(1'b1);
    `CHK(irq_o, 1'b0)
    wr(IRQEN_ADDR, 8'h07);
    rd24(CPER_ADDR, r);
    `CHK(r, v)
    wr(CPER_ADDR, ~v[7:0]);
    rd(CPER_ADDR, b);
    `CHK(b, v[7:0])
    wr(STATE_ADDR, 8'h40);
    rd24(CWID_ADDR, r);
    `CHK(r, v)
    wr24(COUNT_ADDR, ~v);
    cap(1'b0);
    rd24(CWID_ADDR, r);
    `CHK(r, ~v)
    rd(IRQFLAG_ADDR, b);
    `CHK(b, flag_of(FLAG_WIDTH_BIT) | flag_of(FLAG_PERIOD_BIT))
    `CHK(irq_o, 1'b1)
    wr(IRQFLAG_ADDR, 8'h03);
    wr(IRQEN_ADDR, flag_of(FLAG_MATCH_BIT));
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    wr24(PLIM_ADDR, 24'h000005);
    wr24(COUNT_ADDR, 24'h000000);
    wr(CTRL1_ADDR, 8'hc0);
    for (int n = 0; n < 60 && irq_o !== 1'b1; n++) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    rd(IRQFLAG_ADDR, b);
    `CHK(b, flag_of(FLAG_MATCH_BIT))
    wr(CTRL1_ADDR, 8'h00);
    rd24(COUNT_ADDR, r);
    `CHK(r <= 24'h000005, 1'b1)
    wr(CTRL0_ADDR, 8'ha0);
    wr(IRQFLAG_ADDR, 8'h04);
    wr(CTRL1_ADDR, 8'hc0);
    repeat (20) @(posedge clk_i);
    rd24(COUNT_ADDR, r);
    `CHK(r, 24'h000005)
    wr(CTRL1_ADDR, 8'h80);
    cap(1'b1);
    rd(CTRL1_ADDR, b);
    `CHK(b[CTRL1_GO_BIT], 1'b0)
    wr(CTRL0_ADDR, 8'h80);
    sleep_i <= 1'b1;
    wr(CTRL1_ADDR, 8'hc0);
    repeat (6) @(posedge clk_i);
    repeat (8)
    begin
      @(negedge clk_i);
      `CHK(running_o, 1'b0)
    end
    wr(CLKSEL_ADDR, 8'h02);
    saw = 1'b0;
    repeat (8)
    begin
      @(posedge clk_i);
      count_tick_i <= !count_tick_i;
      repeat (3) @(negedge clk_i) saw |= running_o;
    end
    `CHK(saw, 1'b1)
    rd24(COUNT_ADDR, v);
    wr(IRQFLAG_ADDR, 8'h02);
    wr(STATE_ADDR, 8'h80);
    rd24(CPER_ADDR, r);
    `CHK(r, v)
    rd(IRQFLAG_ADDR, b);
    `CHK(b[FLAG_PERIOD_BIT], 1'b1)
    // A second reset in mid-run must leave the captured period alone.
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd24(CPER_ADDR, r);
    `CHK(r, v)
    rd24(COUNT_ADDR, r);
    `CHK(r, COUNT_RESET)
    repeat (3)
    begin
      v = 24'($random(seed));
      wr(CLKSEL_ADDR, v[7:0]);
      wr(SIGSEL_ADDR, v[15:8]);
      wr(WINSEL_ADDR, v[23:16]);
      rd(CLKSEL_ADDR, b);
      `CHK(b, v[7:0] & CLKSEL_MASK)
      rd(SIGSEL_ADDR, b);
      `CHK(b, v[15:8] & SRCSEL_MASK)
      rd(WINSEL_ADDR, b);
      `CHK(b, v[23:16] & SRCSEL_MASK)
    end
    complete_run();
  end
endmodule
`default_nettype wire
